// ===== core/wcfr_pin_mux.sv
// fault pin driver: picks source and drive style from the select code
`timescale 1ns/1ps
`default_nettype none
module wcfr_pin_mux (
	input wire logic clock,
	input wire logic reset_n,
	wcfr_pins_if.drv pins
);
	import wcfr_pkg::*;
	logic out_next;
	logic oe_next;
	logic out_reg;
	logic oe_reg;

	// open drain drives only low, push-pull drives both levels
	always_comb begin
		out_next = 1'b0;
		oe_next = 1'b0;
		if (pins.pin_select == WCFR_PIN_FAULT) begin
			oe_next = pins.fault_sig;
		end else if (pins.pin_select == WCFR_PIN_WARN) begin
			oe_next = pins.warn_sig;
		end else if (pins.pin_select == WCFR_PIN_CLIP1) begin
			oe_next = 1'b1;
			out_next = pins.group_one;
		end else if (pins.pin_select == WCFR_PIN_CLIP2) begin
			oe_next = 1'b1;
			out_next = pins.group_two;
		end else begin
			oe_next = 1'b0;
		end
	end

	// registered so the pin never glitches during source changes
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			out_reg <= 1'b0;
			oe_reg <= 1'b0;
		end else begin
			out_reg <= out_next;
			oe_reg <= oe_next;
		end
	end
	assign pins.pin_out = out_reg;
	assign pins.pin_oe = oe_reg;

	property p_od_fault;
		@(posedge clock) disable iff (!reset_n)
		pins.pin_select == WCFR_PIN_FAULT |=> !pins.pin_out
			&& pins.pin_oe == $past(pins.fault_sig);
	endproperty
	a_od_fault: assert property (p_od_fault)
		else $error("fault open drain drive wrong");
	property p_od_warn;
		@(posedge clock) disable iff (!reset_n)
		pins.pin_select == WCFR_PIN_WARN && pins.warn_sig
			|=> pins.pin_oe && !pins.pin_out;
	endproperty
	a_od_warn: assert property (p_od_warn)
		else $error("warning pin not pulled low");
	property p_pp_one;
		@(posedge clock) disable iff (!reset_n)
		pins.pin_select == WCFR_PIN_CLIP1 |=> pins.pin_oe
			&& pins.pin_out == $past(pins.group_one);
	endproperty
	a_pp_one: assert property (p_pp_one)
		else $error("group one push-pull wrong");
	property p_pp_two;
		@(posedge clock) disable iff (!reset_n)
		pins.pin_select == WCFR_PIN_CLIP2 |=> pins.pin_oe
			&& pins.pin_out == $past(pins.group_two);
	endproperty
	a_pp_two: assert property (p_pp_two)
		else $error("group two push-pull wrong");
	property p_undef;
		@(posedge clock) disable iff (!reset_n)
		pins.pin_select > WCFR_PIN_CLIP2 |=> !pins.pin_oe;
	endproperty
	a_undef: assert property (p_undef)
		else $error("undefined code drives pin");
	c_pp_high: cover property (@(posedge clock) disable iff (!reset_n)
		pins.pin_oe && pins.pin_out);
endmodule
`default_nettype wire

// ===== core/wcfr_pins_if.sv
// bundle carrying the decoded pin drive between router modules
`timescale 1ns/1ps
`default_nettype none
interface wcfr_pins_if;
	logic [3:0] pin_select;
	logic fault_sig;
	logic warn_sig;
	logic group_one;
	logic group_two;
	logic pin_out;
	logic pin_oe;
	modport src(output pin_select, fault_sig, warn_sig, group_one,
		group_two, input pin_out, pin_oe);
	modport drv(input pin_select, fault_sig, warn_sig, group_one,
		group_two, output pin_out, pin_oe);
endinterface
`default_nettype wire

// ===== core/wcfr_pkg.sv
// constants for the warning, clip and fault signal router
// Overview of operation
// - Enable bit 5 lets live clock-invalid flag raise the warning.
// - Enable bit 4 lets any thermal shutdown flag raise the warning.
// - Enable bit 3 lets any supply fault flag raise the warning.
// - Enable bit 2 lets any thermal warning flag raise the warning.
// - Enable bit 1 lets the gain foldback warning raise the warning.
// - Enable bit 0 raises warning while any load diagnostic is unfinished.
// - Clip groups stay low unless clip enable bit 6 is set.
// - Threshold bits 5-4 pick 2, 5, 10 or 1 percent distortion.
// - Bit 3 routes channel 3 and 4 clips to group two.
// - Bit 2 routes channel 3 and 4 clips to group one.
// - Bit 1 routes channel 1 and 2 clips to group two.
// - Bit 0 routes channel 1 and 2 clips to group one.
// - Pin code 0000 pulls pin low while fault is active.
// - Pin code 0001 pulls pin low while warning is active.
// - Pin code 0010 drives pin push-pull high with clip group one.
// - Pin code 0011 drives pin push-pull high with clip group two.
// - Fault-on-warning input fault_on_warn_en also raises fault when warning is active.
`default_nettype none
package wcfr_pkg;
	// register index as numbered; the apb byte address is four times it
	localparam logic [11:0] WCFR_IDX_WARN = 12'h020;
	localparam logic [11:0] WCFR_IDX_CLIP = 12'h021;
	localparam logic [11:0] WCFR_IDX_PIN = 12'h022;
	localparam logic [11:0] WCFR_IDX_STAT = 12'h023;
	localparam logic [11:0] WCFR_OFF_WARN = WCFR_IDX_WARN << 2;
	localparam logic [11:0] WCFR_OFF_CLIP = WCFR_IDX_CLIP << 2;
	localparam logic [11:0] WCFR_OFF_PIN = WCFR_IDX_PIN << 2;
	localparam logic [11:0] WCFR_OFF_STAT = WCFR_IDX_STAT << 2;
	localparam logic [7:0] WCFR_RST_REG = 8'h00;
	localparam int WCFR_B_CLOCK = 5;
	localparam int WCFR_B_THERMAL_SHUTDOWN_FLAG = 4;
	localparam int WCFR_B_POWER = 3;
	localparam int WCFR_B_OTW = 2;
	localparam int WCFR_B_TGFB = 1;
	localparam int WCFR_B_LDG = 0;
	localparam int WCFR_B_CLIP_EN = 6;
	localparam int WCFR_B_LVL_HI = 5;
	localparam int WCFR_B_LVL_LO = 4;
	localparam int WCFR_B_REAR_G2 = 3;
	localparam int WCFR_B_REAR_G1 = 2;
	localparam int WCFR_B_FRONT_G2 = 1;
	localparam int WCFR_B_FRONT_G1 = 0;
	localparam logic [3:0] WCFR_PIN_FAULT = 4'h0;
	localparam logic [3:0] WCFR_PIN_WARN = 4'h1;
	localparam logic [3:0] WCFR_PIN_CLIP1 = 4'h2;
	localparam logic [3:0] WCFR_PIN_CLIP2 = 4'h3;
	localparam logic [1:0] WCFR_LVL_2PCT = 2'h0;
	localparam logic [1:0] WCFR_LVL_5PCT = 2'h1;
	localparam logic [1:0] WCFR_LVL_10PCT = 2'h2;
	localparam logic [1:0] WCFR_LVL_1PCT = 2'h3;
endpackage
`default_nettype wire

// ===== core/wcfr_router.sv
// top of the warning, clip and fault signal router with apb registers
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module wcfr_router (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic clock_invalid_flag,
	input wire logic [3:0] thermal_shutdown_flag,
	input wire logic thermal_shutdown_global_flag,
	input wire logic [3:0] thermal_warning_flag,
	input wire logic thermal_warning_global_flag,
	input wire logic battery_undervoltage_flag,
	input wire logic battery_overvoltage_flag,
	input wire logic power_stage_undervoltage_flag,
	input wire logic power_stage_overvoltage_flag,
	input wire logic gate_supply_fault_flag,
	input wire logic gain_foldback_warning,
	input wire logic [3:0] load_diag_done_flag,
	input wire logic [3:0] channel_clip_flag,
	input wire logic fault_on_warn_en,
	input wire logic fault_source_in,
	output logic warning_sig,
	output logic fault_sig,
	output logic clip_group_one,
	output logic clip_group_two,
	output logic [1:0] clip_threshold_select,
	output logic clip_detect_enable,
	output logic fault_pin_out,
	output logic fault_pin_oe
);
	import wcfr_pkg::*;
	// flag inputs come from analog monitors in another domain
	localparam int NFLAG = 27;
	logic [NFLAG-1:0] flag_raw;
	logic [NFLAG-1:0] flag_meta_reg;
	logic [NFLAG-1:0] flag_sync_reg;
	logic [7:0] warn_en_reg;
	logic [7:0] clip_cfg_reg;
	logic [7:0] pin_sel_reg;
	logic warn_next;
	logic fault_next;
	logic g1_next;
	logic g2_next;
	logic warning_reg;
	logic fault_reg;
	logic g1_reg;
	logic g2_reg;
	logic clock_bad_s;
	logic [3:0] thermal_shutdown_flag_s;
	logic thermal_shutdown_flag_g_s;
	logic [3:0] otw_s;
	logic otw_g_s;
	logic [4:0] power_s;
	logic tgfb_s;
	logic [3:0] ldg_s;
	logic [3:0] clip_s;
	logic fow_s;
	logic fsrc_s;
	logic access;
	wcfr_pins_if pins();

	// any bit set in a vector
	function automatic logic any4(input logic [3:0] v);
		return |v;
	endfunction

	assign flag_raw = {clock_invalid_flag, thermal_shutdown_flag,
		thermal_shutdown_global_flag, thermal_warning_flag,
		thermal_warning_global_flag, battery_undervoltage_flag,
		battery_overvoltage_flag, power_stage_undervoltage_flag,
		power_stage_overvoltage_flag, gate_supply_fault_flag,
		gain_foldback_warning, load_diag_done_flag, channel_clip_flag,
		fault_on_warn_en, fault_source_in};

	// two-stage synchroniser; only the second stage is read
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			flag_meta_reg <= '0;
			flag_sync_reg <= '0;
		end else begin
			flag_meta_reg <= flag_raw;
			flag_sync_reg <= flag_meta_reg;
		end
	end
	assign {clock_bad_s, thermal_shutdown_flag_s, thermal_shutdown_flag_g_s, otw_s, otw_g_s, power_s, tgfb_s,
		ldg_s, clip_s, fow_s, fsrc_s} = flag_sync_reg;

	// apb answers in the access cycle, no wait states
	assign access = psel && penable;
	assign pready = 1'b1;
	always_comb begin
		pslverr = 1'b0;
		if (access && paddr != WCFR_OFF_WARN && paddr != WCFR_OFF_CLIP
			&& paddr != WCFR_OFF_PIN && paddr != WCFR_OFF_STAT) begin
			pslverr = 1'b1;
		end
	end

	// register writes; reserved bits are kept as written
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			warn_en_reg <= WCFR_RST_REG;
			clip_cfg_reg <= WCFR_RST_REG;
			pin_sel_reg <= WCFR_RST_REG;
		end else if (access && pwrite) begin
			if (paddr == WCFR_OFF_WARN) begin
				warn_en_reg <= pwdata[7:0];
			end else if (paddr == WCFR_OFF_CLIP) begin
				clip_cfg_reg <= pwdata[7:0];
			end else if (paddr == WCFR_OFF_PIN) begin
				pin_sel_reg <= pwdata[7:0];
			end
		end
	end

	// read data registered; unmapped reads return zero
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable && !pwrite) begin
			if (paddr == WCFR_OFF_WARN) begin
				prdata <= {24'h000000, warn_en_reg};
			end else if (paddr == WCFR_OFF_CLIP) begin
				prdata <= {24'h000000, clip_cfg_reg};
			end else if (paddr == WCFR_OFF_PIN) begin
				prdata <= {24'h000000, pin_sel_reg};
			end else if (paddr == WCFR_OFF_STAT) begin
				prdata <= {28'h0000000, g2_reg, g1_reg, fault_reg,
					warning_reg};
			end else begin
				prdata <= 32'h00000000;
			end
		end
	end

	// warning gathers every enabled live source
	always_comb begin
		warn_next = 1'b0;
		if (warn_en_reg[WCFR_B_CLOCK] && clock_bad_s) begin
			warn_next = 1'b1;
		end
		if (warn_en_reg[WCFR_B_THERMAL_SHUTDOWN_FLAG] && (any4(thermal_shutdown_flag_s) || thermal_shutdown_flag_g_s)) begin
			warn_next = 1'b1;
		end
		if (warn_en_reg[WCFR_B_POWER] && (|power_s)) begin
			warn_next = 1'b1;
		end
		// thermal warning source, live flags taken
		if (warn_en_reg[WCFR_B_OTW] && (any4(otw_s) || otw_g_s)) begin
			warn_next = 1'b1;
		end
		if (warn_en_reg[WCFR_B_TGFB] && tgfb_s) begin
			warn_next = 1'b1;
		end
		if (warn_en_reg[WCFR_B_LDG] && !(&ldg_s)) begin
			warn_next = 1'b1;
		end
	end

	// fault is the outside fault source plus optional warning
	always_comb begin
		fault_next = fsrc_s || (fow_s && warn_next);
	end

	// clip groups; threshold is applied by the analog detector
	always_comb begin
		g1_next = 1'b0;
		g2_next = 1'b0;
		if (clip_cfg_reg[WCFR_B_CLIP_EN]) begin
			if (clip_cfg_reg[WCFR_B_REAR_G2]
				&& any4({clip_s[3:2], 2'h0})) begin
				g2_next = 1'b1;
			end
			if (clip_cfg_reg[WCFR_B_REAR_G1]
				&& any4({clip_s[3:2], 2'h0})) begin
				g1_next = 1'b1;
			end
			if (clip_cfg_reg[WCFR_B_FRONT_G2]
				&& any4({2'h0, clip_s[1:0]})) begin
				g2_next = 1'b1;
			end
			if (clip_cfg_reg[WCFR_B_FRONT_G1]
				&& any4({2'h0, clip_s[1:0]})) begin
				g1_next = 1'b1;
			end
		end
	end

	// registered signal outputs
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			warning_reg <= 1'b0;
			fault_reg <= 1'b0;
			g1_reg <= 1'b0;
			g2_reg <= 1'b0;
		end else begin
			warning_reg <= warn_next;
			fault_reg <= fault_next;
			g1_reg <= g1_next;
			g2_reg <= g2_next;
		end
	end
	assign warning_sig = warning_reg;
	assign fault_sig = fault_reg;
	assign clip_group_one = g1_reg;
	assign clip_group_two = g2_reg;
	assign clip_threshold_select = clip_cfg_reg[WCFR_B_LVL_HI:WCFR_B_LVL_LO];
	assign clip_detect_enable = clip_cfg_reg[WCFR_B_CLIP_EN];

	assign pins.pin_select = pin_sel_reg[3:0];
	assign pins.fault_sig = fault_reg;
	assign pins.warn_sig = warning_reg;
	assign pins.group_one = g1_reg;
	assign pins.group_two = g2_reg;
	wcfr_pin_mux u_pin_mux (
		.clock(clock),
		.reset_n(reset_n),
		.pins(pins)
	);
	assign fault_pin_out = pins.pin_out;
	assign fault_pin_oe = pins.pin_oe;

	property p_clock_src;
		@(posedge clock) disable iff (!reset_n)
		warn_en_reg[WCFR_B_CLOCK] && clock_bad_s |=> warning_reg;
	endproperty
	a_clock_src: assert property (p_clock_src)
		else $error("clock invalid did not warn");
	property p_thermal_shutdown_flag_src;
		@(posedge clock) disable iff (!reset_n)
		warn_en_reg[WCFR_B_THERMAL_SHUTDOWN_FLAG] && (|thermal_shutdown_flag_s || thermal_shutdown_flag_g_s)
			|=> warning_reg;
	endproperty
	a_thermal_shutdown_flag_src: assert property (p_thermal_shutdown_flag_src)
		else $error("shutdown flag did not warn");
	property p_power_src;
		@(posedge clock) disable iff (!reset_n)
		warn_en_reg[WCFR_B_POWER] && (|power_s) |=> warning_reg;
	endproperty
	a_power_src: assert property (p_power_src)
		else $error("supply fault did not warn");
	property p_otw_src;
		@(posedge clock) disable iff (!reset_n)
		warn_en_reg[WCFR_B_OTW] && (|otw_s || otw_g_s)
			|=> warning_reg;
	endproperty
	a_otw_src: assert property (p_otw_src)
		else $error("thermal warning did not warn");
	property p_tgfb_src;
		@(posedge clock) disable iff (!reset_n)
		warn_en_reg[WCFR_B_TGFB] && tgfb_s |=> warning_reg;
	endproperty
	a_tgfb_src: assert property (p_tgfb_src)
		else $error("foldback did not warn");
	property p_ldg_src;
		@(posedge clock) disable iff (!reset_n)
		warn_en_reg[WCFR_B_LDG] && ldg_s != 4'hF |=> warning_reg;
	endproperty
	a_ldg_src: assert property (p_ldg_src)
		else $error("unfinished diagnostics did not warn");
	property p_clip_off;
		@(posedge clock) disable iff (!reset_n)
		!clip_cfg_reg[WCFR_B_CLIP_EN] |=> !g1_reg && !g2_reg;
	endproperty
	a_clip_off: assert property (p_clip_off)
		else $error("clip group active while disabled");
	property p_front_g1;
		@(posedge clock) disable iff (!reset_n)
		clip_cfg_reg[WCFR_B_CLIP_EN] && clip_cfg_reg[WCFR_B_FRONT_G1]
			&& (|clip_s[1:0]) |=> g1_reg;
	endproperty
	a_front_g1: assert property (p_front_g1)
		else $error("front clip missed group one");
	property p_rear_g2;
		@(posedge clock) disable iff (!reset_n)
		clip_cfg_reg[WCFR_B_CLIP_EN] && clip_cfg_reg[WCFR_B_REAR_G2]
			&& (|clip_s[3:2]) |=> g2_reg;
	endproperty
	a_rear_g2: assert property (p_rear_g2)
		else $error("rear clip missed group two");
	property p_rear_g1;
		@(posedge clock) disable iff (!reset_n)
		clip_cfg_reg[WCFR_B_CLIP_EN] && clip_cfg_reg[WCFR_B_REAR_G1]
			&& (|clip_s[3:2]) |=> g1_reg;
	endproperty
	a_rear_g1: assert property (p_rear_g1)
		else $error("rear clip missed group one");
	property p_front_g2;
		@(posedge clock) disable iff (!reset_n)
		clip_cfg_reg[WCFR_B_CLIP_EN] && clip_cfg_reg[WCFR_B_FRONT_G2]
			&& (|clip_s[1:0]) |=> g2_reg;
	endproperty
	a_front_g2: assert property (p_front_g2)
		else $error("front clip missed group two");
	property p_fow;
		@(posedge clock) disable iff (!reset_n)
		fow_s && warn_next |=> fault_reg;
	endproperty
	a_fow: assert property (p_fow)
		else $error("fault on warning missing");
	property p_warn_clear;
		@(posedge clock) disable iff (!reset_n)
		warn_en_reg == 8'h00 |=> !warning_reg;
	endproperty
	a_warn_clear: assert property (p_warn_clear)
		else $error("warning without enabled source");
	c_warn: cover property (@(posedge clock) disable iff (!reset_n)
		warning_reg);
	c_g2: cover property (@(posedge clock) disable iff (!reset_n) g2_reg);
	c_wr: cover property (@(posedge clock) disable iff (!reset_n)
		access && pwrite && paddr == WCFR_OFF_PIN);
endmodule
`default_nettype wire

// ===== sim/test_wcfr_router.sv
// self-checking bench for the warning, clip and fault router
`timescale 1ns/1ps
`default_nettype none
module test_wcfr_router;
	import wcfr_pkg::*;
	logic clock, reset_n, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic ck_bad, ts_g, tw_g, bat_uv, bat_ov, ps_uv, ps_ov, gate_f, fold;
	logic [3:0] ts, tw, ld_done, clip;
	logic fow_en, f_src, warn, fault, g1, g2, clip_en, p_out, p_oe, level;
	logic [1:0] lvl;
	logic err;
	int err_total, tests_run;

	wcfr_router uut (.clock(clock), .reset_n(reset_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .clock_invalid_flag(ck_bad),
		.thermal_shutdown_flag(ts), .thermal_shutdown_global_flag(ts_g),
		.thermal_warning_flag(tw), .thermal_warning_global_flag(tw_g),
		.battery_undervoltage_flag(bat_uv),
		.battery_overvoltage_flag(bat_ov),
		.power_stage_undervoltage_flag(ps_uv),
		.power_stage_overvoltage_flag(ps_ov),
		.gate_supply_fault_flag(gate_f), .gain_foldback_warning(fold),
		.load_diag_done_flag(ld_done), .channel_clip_flag(clip),
		.fault_on_warn_en(fow_en), .fault_source_in(f_src),
		.warning_sig(warn), .fault_sig(fault), .clip_group_one(g1),
		.clip_group_two(g2), .clip_threshold_select(lvl),
		.clip_detect_enable(clip_en), .fault_pin_out(p_out),
		.fault_pin_oe(p_oe));
	wcfr_host_model host (.drive_out(p_out), .drive_en(p_oe),
		.pin_level(level));

	// 10 MHz clock
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	task automatic results;
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// run is a few hundred cycles, so this only trips on a hang
	initial begin
		repeat (20000) @(posedge clock);
		err_total++;
		results();
	end

	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one apb transfer; request held until pready is sampled high
	task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		// only the watchdog ends a wait that never sees pready
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask

	// flags pass two sync flops and a register, so give them time
	task automatic settle;
		repeat (6) @(posedge clock);
	endtask

	task automatic set_src(int b, logic v);
		case (b)
			5: ck_bad <= v;
			4: ts_g <= v;
			3: gate_f <= v;
			2: tw[2] <= v;
			1: fold <= v;
			default: ld_done[1] <= ~v;
		endcase
	endtask

	logic [11:0] regs [3] = '{WCFR_OFF_WARN, WCFR_OFF_CLIP, WCFR_OFF_PIN};

	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{ck_bad, ts_g, tw_g, bat_uv, bat_ov, ps_uv, ps_ov} = '0;
		{gate_f, fold, ts, tw, clip, fow_en, f_src} = '0;
		ld_done = 4'hF;
		reset_n = 1'b0;
		err_total = 0;
		tests_run = 0;
		repeat (20) @(posedge clock);
		reset_n <= 1'b1;
		@(posedge clock);
		// reset values, then the unmapped word
		foreach (regs[i]) begin
			apb(1'b0, regs[i], 32'h0);
			chk("reset value", 32'h0, rd);
		end
		apb(1'b0, 12'h090, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, err});
		// reserved bits read back and steer nothing
		ck_bad <= 1'b1;
		apb(1'b1, WCFR_OFF_WARN, 32'hFFFF_FFC0);
		apb(1'b0, WCFR_OFF_WARN, 32'h0);
		chk("warn reg", 32'h0000_00C0, rd);
		settle();
		chk("warn reserved", 32'h0, {31'h0, warn});
		ck_bad <= 1'b0;
		// each source raises warning only under its own enable bit
		for (int b = 0; b < 6; b++) begin
			set_src(b, 1'b1);
			apb(1'b1, WCFR_OFF_WARN, 32'h3F & ~(32'h1 << b));
			settle();
			chk("masked", 32'h0, {31'h0, warn});
			apb(1'b1, WCFR_OFF_WARN, 32'h1 << b);
			settle();
			chk("enabled", 32'h1, {31'h0, warn});
			set_src(b, 1'b0);
		end
		// warning holds until the last enabled source clears
		apb(1'b1, WCFR_OFF_WARN, 32'h18);
		ts[0] <= 1'b1;
		bat_ov <= 1'b1;
		settle();
		ts[0] <= 1'b0;
		settle();
		chk("warn held", 32'h1, {31'h0, warn});
		apb(1'b0, WCFR_OFF_STAT, 32'h0);
		chk("status", 32'h1, rd & 32'h1);
		apb(1'b1, WCFR_OFF_PIN, {28'h0, WCFR_PIN_WARN});
		settle();
		chk("pin warn", 32'h0, {31'h0, level});
		bat_ov <= 1'b0;
		settle();
		chk("warn off", 32'h0, {31'h0, warn});
		chk("pin idle", 32'h1, {31'h0, level});
		// fault pin code and fault on warning
		apb(1'b1, WCFR_OFF_PIN, {28'h0, WCFR_PIN_FAULT});
		f_src <= 1'b1;
		settle();
		chk("pin fault", 32'h0, {31'h0, level});
		f_src <= 1'b0;
		fow_en <= 1'b1;
		fold <= 1'b1;
		apb(1'b1, WCFR_OFF_WARN, 32'h02);
		settle();
		chk("fault on warn", 32'h1, {31'h0, fault});
		// undefined codes release the pin
		for (int c = 4; c < 16; c++) begin
			apb(1'b1, WCFR_OFF_PIN, c);
			settle();
			chk("pin released", 32'h0, {31'h0, p_oe});
		end
		fold <= 1'b0;
		fow_en <= 1'b0;
		// clip routing: one routing bit at a time, detection on and off
		for (int r = 0; r < 4; r++) begin
			clip <= (r < 2) ? 4'h2 : 4'h8;
			apb(1'b1, WCFR_OFF_CLIP, 32'h1 << r);
			settle();
			chk("clip off", 32'h0, {30'h0, g2, g1});
			chk("detect off", 32'h0, {31'h0, clip_en});
			apb(1'b1, WCFR_OFF_CLIP, 32'h40 | (32'h1 << r));
			apb(1'b1, WCFR_OFF_PIN, (r % 2) ? 32'h3 : 32'h2);
			settle();
			chk("group one", {31'h0, !r[0]}, {31'h0, g1});
			chk("group two", {31'h0, r[0]}, {31'h0, g2});
			chk("push pull", 32'h3, {30'h0, p_oe, p_out});
			clip <= 4'h0;
			settle();
			chk("pin low", 32'h2, {30'h0, p_oe, p_out});
		end
		// every threshold code is forwarded
		for (int l = 0; l < 4; l++) begin
			apb(1'b1, WCFR_OFF_CLIP, 32'h40 | (l << 4));
			settle();
			chk("threshold", l, {30'h0, lvl});
			chk("clip enable", 32'h1, {31'h0, clip_en});
		end
		results();
	end
endmodule
`default_nettype wire

// ===== sim/wcfr_host_model.sv
// host side of the fault pin: pull-up resistor
`timescale 1ns/1ps
`default_nettype none
module wcfr_host_model (
	input wire logic drive_out,
	input wire logic drive_en,
	output logic pin_level
);
	// open drain resolve
	// released pin floats up through the host pull-up resistor
	always_comb begin
		pin_level = drive_en ? drive_out : 1'b1;
	end
endmodule
`default_nettype wire
